/* acm_fault_monitor.sv */
// Audio input clock and data fault monitor with its AXI4-Lite register file.
// Notes on behaviour
// - Data checks have own enables; run only when enabled and speaker amplifier on.
// - Tone generator enabled suspends the data checks completely.
// - Persistent data fault clears global enable and pulses the data fault interrupt.
// - Repeated equal samples above stuck threshold beyond duration give stuck fault.
// - Repeated samples within stuck threshold never give a stuck fault.
// - Samples beyond magnitude threshold for longer than duration give magnitude fault.
// - Clock watch runs when enabled and out of shutdown; tone generator suspends it.
// - Checks activity, frequency and ratio; confirmed fault shuts down and interrupts.
// - Auto recover keeps global enable; error and recovery interrupts come in pairs.
// - Manual mode clears global enable and never issues a recovery interrupt.
// - After host re-enables, clock watch restarts and can fault again.
// - Host-driven shutdown entry and exit raise no clock interrupts.
// - Clock watch enable resets to one.
// - Expected frame clock is sample rate; bit clock is rate times ratio.
// - Each frame period measures both clocks; deviation over 45 percent is error.
// - Clock error after the set number of consecutive frequency error frames.
// - Auto mode recovers after that many consecutive frequency-clean frames.
// - Bit clocks per frame match the ratio; non-TDM halves must be equal.
// - TDM format applies no frame clock duty check.
// - Clock error after the set number of consecutive framing error frames.
// - Auto mode recovers after that many consecutive framing-clean frames.
`timescale 1ns/1ps
module acm_fault_monitor (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bclk,
  input  wire logic        lrclk,
  input  wire logic [23:0] sample_data,
  input  wire logic        sample_valid,
  output logic             amp_active,
  output logic             data_fault_interrupt,
  output logic             clock_error_interrupt,
  output logic             clock_recover_interrupt
);
  typedef struct packed {
    logic [6:0]            ctrl;
    logic [22:0]           cfg;
    logic [22:0]           stuck_thr;
    logic [22:0]           mag_thr;
    logic [2:0]            flags;
    logic                  aw_got;
    logic [7:0]            aw_addr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    acm_pkg::acm_cm_state_t cm;
    logic [15:0]           win_cnt;
    logic [15:0]           win_bclk;
    logic [1:0]            win_lr;
    logic                  fr_started;
    logic [15:0]           fr_hi;
    logic [15:0]           fr_lo;
    logic [4:0]            fer_run;
    logic [4:0]            fok_run;
    logic [4:0]            ber_run;
    logic [4:0]            bok_run;
    logic                  amp;
    logic                  dm_irq;
    logic                  ce_irq;
    logic                  cr_irq;
  } acm_top_t;

  acm_top_t    r;
  acm_top_t    next_r;
  logic        bclk_lvl;
  logic        bclk_rise;
  logic        lr_lvl;
  logic        lr_rise;
  logic        dmon_active;
  logic        dmon_fault;
  logic        cm_active;
  logic        win_end;
  logic        freq_bad;
  logic        frame_bad;
  logic [4:0]  f_thr;
  logic [4:0]  b_thr;
  logic        clk_fault;
  logic [31:0] merged;
  logic [2:0]  set_flags;

  function automatic logic in_tol(input logic [15:0] cnt, input logic [15:0] expct);
    logic [31:0] a;
    logic [31:0] lo;
    logic [31:0] hi;
    a      = {16'h0000, cnt} * 32'd100;
    lo     = {16'h0000, expct} * 32'(acm_pkg::FREQ_LO_PCT);
    hi     = {16'h0000, expct} * 32'(acm_pkg::FREQ_HI_PCT);
    in_tol = (a >= lo) && (a <= hi);
  endfunction : in_tol

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == acm_pkg::ADDR_CTRL) || (a == acm_pkg::ADDR_CFG) || (a == acm_pkg::ADDR_STUCK) ||
             (a == acm_pkg::ADDR_MAG) || (a == acm_pkg::ADDR_STATUS);
  endfunction : mapped

  function automatic logic [4:0] bump(input logic [4:0] v);
    bump = (v == 5'h1F) ? v : 5'(v + 5'h01);
  endfunction : bump

  acm_pin_edge u_bclk_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (bclk),
    .level   (bclk_lvl),
    .rise    (bclk_rise)
  );

  acm_pin_edge u_lrclk_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (lrclk),
    .level   (lr_lvl),
    .rise    (lr_rise)
  );

  assign dmon_active = r.ctrl[acm_pkg::B_GEN] & r.ctrl[acm_pkg::B_SPK] & ~r.ctrl[acm_pkg::B_TONE] &
                       (r.cm != acm_pkg::CM_FAULT);

  acm_data_mon u_data_mon (
    .clk          (clk),
    .reset_n      (reset_n),
    .active       (dmon_active),
    .mag_en       (r.ctrl[acm_pkg::B_MAGEN]),
    .stuck_en     (r.ctrl[acm_pkg::B_STKEN]),
    .stuck_thr    (r.stuck_thr),
    .mag_thr      (r.mag_thr),
    .dur_code     (r.cfg[acm_pkg::F_DUR +: 3]),
    .sample_data  (sample_data),
    .sample_valid (sample_valid),
    .fault        (dmon_fault)
  );

  always_comb begin
    next_r        = r;
    next_r.dm_irq = 1'b0;
    next_r.ce_irq = 1'b0;
    next_r.cr_irq = 1'b0;
    merged        = '0;
    set_flags     = '0;
    cm_active     = r.ctrl[acm_pkg::B_GEN] & r.ctrl[acm_pkg::B_CMEN] & ~r.ctrl[acm_pkg::B_TONE];
    win_end       = (r.win_cnt == 16'(acm_pkg::acm_frame_cycles(r.cfg[acm_pkg::F_SR +: 3]) - 16'h0001));
    freq_bad      = ~in_tol({14'h0000, r.win_lr}, 16'h0001) |
                    ~in_tol(r.win_bclk, acm_pkg::acm_ratio(r.cfg[acm_pkg::F_BSEL +: 3]));
    frame_bad     = (16'(r.fr_hi + r.fr_lo) != acm_pkg::acm_ratio(r.cfg[acm_pkg::F_BSEL +: 3])) ||
                    ((r.cfg[acm_pkg::F_FMT +: 2] != acm_pkg::FMT_TDM) && (r.fr_hi != r.fr_lo));
    f_thr         = 5'({1'b0, r.cfg[acm_pkg::F_ERRTOL +: 4]} + 5'h01);
    b_thr         = 5'({1'b0, r.cfg[acm_pkg::F_BSELTOL +: 4]} + 5'h01);
    clk_fault     = (r.fer_run >= f_thr) || (r.ber_run >= b_thr);

    // Register bus: address and data are taken in either order, answer once both are in.
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.bvalid = 1'b1;
      next_r.bresp  = mapped(r.aw_addr) ? acm_pkg::RESP_OKAY : acm_pkg::RESP_SLVERR;
      case (r.aw_addr)
        acm_pkg::ADDR_CTRL: begin
          merged      = merge({25'h0, r.ctrl}, r.wdata, r.wstrb);
          next_r.ctrl = merged[6:0];
        end
        acm_pkg::ADDR_CFG: begin
          merged     = merge({9'h0, r.cfg}, r.wdata, r.wstrb);
          next_r.cfg = merged[22:0];
        end
        acm_pkg::ADDR_STUCK: begin
          merged           = merge({9'h0, r.stuck_thr}, r.wdata, r.wstrb);
          next_r.stuck_thr = merged[22:0];
        end
        acm_pkg::ADDR_MAG: begin
          merged         = merge({9'h0, r.mag_thr}, r.wdata, r.wstrb);
          next_r.mag_thr = merged[22:0];
        end
        acm_pkg::ADDR_STATUS: begin
          if (r.wstrb[0]) begin
            next_r.flags = r.flags & ~r.wdata[2:0];
          end
        end
        default: begin
          merged = '0;
        end
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = mapped(s_axi_araddr) ? acm_pkg::RESP_OKAY : acm_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        acm_pkg::ADDR_CTRL:   next_r.rdata = {25'h0, r.ctrl};
        acm_pkg::ADDR_CFG:    next_r.rdata = {9'h0, r.cfg};
        acm_pkg::ADDR_STUCK:  next_r.rdata = {9'h0, r.stuck_thr};
        acm_pkg::ADDR_MAG:    next_r.rdata = {9'h0, r.mag_thr};
        acm_pkg::ADDR_STATUS: next_r.rdata = {25'h0, r.cm == acm_pkg::CM_FAULT, r.amp, 2'h0, r.flags};
        default:              next_r.rdata = '0;
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // Frequency window: one programmed frame period per measurement.
    if (!cm_active) begin
      next_r.win_cnt  = '0;
      next_r.win_bclk = '0;
      next_r.win_lr   = '0;
    end else if (win_end) begin
      next_r.win_cnt  = '0;
      next_r.win_bclk = {15'h0000, bclk_rise};
      next_r.win_lr   = {1'b0, lr_rise};
    end else begin
      next_r.win_cnt  = 16'(r.win_cnt + 16'h0001);
      next_r.win_bclk = (bclk_rise && r.win_bclk != 16'hFFFF) ? 16'(r.win_bclk + 16'h0001) : r.win_bclk;
      next_r.win_lr   = (lr_rise && r.win_lr != 2'h3) ? 2'(r.win_lr + 2'h1) : r.win_lr;
    end

    // Frame ratio: bit clocks in each half of the frame clock.
    if (!cm_active) begin
      next_r.fr_started = 1'b0;
      next_r.fr_hi      = '0;
      next_r.fr_lo      = '0;
    end else begin
      if (lr_rise) begin
        next_r.fr_started = 1'b1;
        next_r.fr_hi      = '0;
        next_r.fr_lo      = '0;
      end
      if (bclk_rise) begin
        if (lr_lvl) begin
          next_r.fr_hi = lr_rise ? 16'h0001 : 16'(r.fr_hi + 16'h0001);
        end else begin
          next_r.fr_lo = 16'(r.fr_lo + 16'h0001);
        end
      end
    end

    // Persistence counters for consecutive faulty and clean frames.
    if (!cm_active) begin
      next_r.fer_run = '0;
      next_r.fok_run = '0;
      next_r.ber_run = '0;
      next_r.bok_run = '0;
    end else begin
      if (win_end) begin
        next_r.fer_run = freq_bad ? bump(r.fer_run) : 5'h00;
        next_r.fok_run = freq_bad ? 5'h00 : bump(r.fok_run);
      end
      if (lr_rise && r.fr_started) begin
        next_r.ber_run = frame_bad ? bump(r.ber_run) : 5'h00;
        next_r.bok_run = frame_bad ? 5'h00 : bump(r.bok_run);
      end
    end

    // Clock watch state: idle when off or host-shut, so host transitions stay silent.
    case (r.cm)
      acm_pkg::CM_IDLE: begin
        if (cm_active) begin
          next_r.cm = acm_pkg::CM_RUN;
        end
      end
      acm_pkg::CM_RUN: begin
        if (!cm_active) begin
          next_r.cm = acm_pkg::CM_IDLE;
        end else if (clk_fault) begin
          next_r.ce_irq  = 1'b1;
          set_flags[acm_pkg::S_CERR] = 1'b1;
          next_r.fer_run = '0;
          next_r.fok_run = '0;
          next_r.ber_run = '0;
          next_r.bok_run = '0;
          if (r.ctrl[acm_pkg::B_AUTO]) begin
            next_r.cm = acm_pkg::CM_FAULT;
          end else begin
            next_r.cm = acm_pkg::CM_IDLE;
            next_r.ctrl[acm_pkg::B_GEN] = 1'b0;
          end
        end
      end
      acm_pkg::CM_FAULT: begin
        if (!cm_active) begin
          next_r.cm = acm_pkg::CM_IDLE;
        end else if (!r.ctrl[acm_pkg::B_AUTO]) begin
          next_r.cm = acm_pkg::CM_IDLE;
          next_r.ctrl[acm_pkg::B_GEN] = 1'b0;
        end else if (r.fok_run >= f_thr && r.bok_run >= b_thr) begin
          next_r.cm     = acm_pkg::CM_RUN;
          next_r.cr_irq = 1'b1;
          set_flags[acm_pkg::S_CREC] = 1'b1;
          next_r.fok_run = '0;
          next_r.bok_run = '0;
        end
      end
      default: begin
        next_r.cm = acm_pkg::CM_IDLE;
      end
    endcase

    if (dmon_fault) begin
      next_r.ctrl[acm_pkg::B_GEN] = 1'b0;
      next_r.dm_irq = 1'b1;
      set_flags[acm_pkg::S_DFAULT] = 1'b1;
    end
    next_r.flags = next_r.flags | set_flags;
    next_r.amp   = next_r.ctrl[acm_pkg::B_GEN] & next_r.ctrl[acm_pkg::B_SPK] & (next_r.cm != acm_pkg::CM_FAULT);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r           <= '0;
      r.ctrl      <= acm_pkg::CTRL_RESET;
      r.cfg       <= acm_pkg::CFG_RESET;
      r.stuck_thr <= acm_pkg::THR_RESET;
      r.mag_thr   <= acm_pkg::THR_RESET;
      r.cm        <= acm_pkg::CM_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready           = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready            = ~r.w_got & ~r.bvalid;
  assign s_axi_bvalid            = r.bvalid;
  assign s_axi_bresp             = r.bresp;
  assign s_axi_arready           = ~r.rvalid;
  assign s_axi_rvalid            = r.rvalid;
  assign s_axi_rdata             = r.rdata;
  assign s_axi_rresp             = r.rresp;
  assign amp_active              = r.amp;
  assign data_fault_interrupt    = r.dm_irq;
  assign clock_error_interrupt   = r.ce_irq;
  assign clock_recover_interrupt = r.cr_irq;
endmodule : acm_fault_monitor

/* acm_pkg.sv */
// Shared constants, register map and types for the audio clock and data fault monitor.
package acm_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_CFG     = 8'h04;
  localparam logic [7:0]  ADDR_STUCK   = 8'h08;
  localparam logic [7:0]  ADDR_MAG     = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS  = 8'h10;
  // Control word: enable, speaker, tone, magnitude, stuck, clock watch, auto recover.
  localparam int          CTRL_W       = 7;
  localparam logic [6:0]  CTRL_RESET   = 7'h20;
  localparam int          B_GEN        = 0;
  localparam int          B_SPK        = 1;
  localparam int          B_TONE       = 2;
  localparam int          B_MAGEN      = 3;
  localparam int          B_STKEN      = 4;
  localparam int          B_CMEN       = 5;
  localparam int          B_AUTO       = 6;
  localparam int          CFG_W        = 23;
  localparam logic [22:0] CFG_RESET    = 23'h011104;
  localparam int          F_SR         = 0;
  localparam int          F_BSEL       = 4;
  localparam int          F_FMT        = 8;
  localparam int          F_ERRTOL     = 12;
  localparam int          F_BSELTOL    = 16;
  localparam int          F_DUR        = 20;
  localparam logic [1:0]  FMT_TDM      = 2'h2;
  localparam logic [22:0] THR_RESET    = 23'h7FFFFF;
  localparam int          S_DFAULT     = 0;
  localparam int          S_CERR       = 1;
  localparam int          S_CREC       = 2;
  localparam logic [15:0] DUR_BASE     = 16'h0040;
  localparam int unsigned FREQ_LO_PCT  = 55;
  localparam int unsigned FREQ_HI_PCT  = 145;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {CM_IDLE, CM_RUN, CM_FAULT} acm_cm_state_t;

  // Frame period in system clock cycles for each sample rate code.
  function automatic logic [15:0] acm_frame_cycles(input logic [2:0] sr);
    case (sr)
      3'h0:    acm_frame_cycles = 16'(CLK_HZ / 8000);
      3'h1:    acm_frame_cycles = 16'(CLK_HZ / 16000);
      3'h2:    acm_frame_cycles = 16'(CLK_HZ / 32000);
      3'h3:    acm_frame_cycles = 16'(CLK_HZ / 44100);
      3'h4:    acm_frame_cycles = 16'(CLK_HZ / 48000);
      3'h5:    acm_frame_cycles = 16'(CLK_HZ / 88200);
      3'h6:    acm_frame_cycles = 16'(CLK_HZ / 96000);
      default: acm_frame_cycles = 16'(CLK_HZ / 192000);
    endcase
  endfunction : acm_frame_cycles

  // Bit clocks per frame for each ratio code.
  function automatic logic [15:0] acm_ratio(input logic [2:0] code);
    case (code)
      3'h0:    acm_ratio = 16'h0010;
      3'h1:    acm_ratio = 16'h0018;
      3'h2:    acm_ratio = 16'h0020;
      3'h3:    acm_ratio = 16'h0030;
      3'h4:    acm_ratio = 16'h0040;
      3'h5:    acm_ratio = 16'h0060;
      3'h6:    acm_ratio = 16'h0080;
      default: acm_ratio = 16'h0100;
    endcase
  endfunction : acm_ratio
endpackage : acm_pkg

/* acm_pin_edge.sv */
// Two-flop synchroniser with edge detection for one clock pin.
`timescale 1ns/1ps
module acm_pin_edge (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } acm_edge_t;

  acm_edge_t r;
  acm_edge_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.s2;
  assign rise  = r.s2 & ~r.s3;
endmodule : acm_pin_edge

/* acm_data_mon.sv */
// Stuck and magnitude checker for incoming sample words.
`timescale 1ns/1ps
module acm_data_mon (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        active,
  input  wire logic        mag_en,
  input  wire logic        stuck_en,
  input  wire logic [22:0] stuck_thr,
  input  wire logic [22:0] mag_thr,
  input  wire logic [2:0]  dur_code,
  input  wire logic [23:0] sample_data,
  input  wire logic        sample_valid,
  output logic             fault
);
  typedef struct packed {
    logic [23:0] prev;
    logic        have_prev;
    logic [15:0] stk_run;
    logic [15:0] mag_run;
    logic        fault;
  } acm_dmon_t;

  acm_dmon_t   r;
  acm_dmon_t   next_r;
  logic [23:0] mag;
  logic [15:0] dur;

  always_comb begin
    next_r       = r;
    next_r.fault = 1'b0;
    mag          = sample_data[23] ? 24'(~sample_data + 24'h000001) : sample_data;
    dur          = 16'(DUR_BASE_SHIFT(dur_code));
    if (!active) begin
      next_r = '0;
    end else if (sample_valid) begin
      next_r.prev      = sample_data;
      next_r.have_prev = 1'b1;
      if (stuck_en && r.have_prev && sample_data == r.prev && mag > {1'b0, stuck_thr}) begin
        next_r.stk_run = (r.stk_run == 16'hFFFF) ? r.stk_run : 16'(r.stk_run + 16'h0001);
      end else begin
        next_r.stk_run = '0;
      end
      if (mag_en && mag > {1'b0, mag_thr}) begin
        next_r.mag_run = (r.mag_run == 16'hFFFF) ? r.mag_run : 16'(r.mag_run + 16'h0001);
      end else begin
        next_r.mag_run = '0;
      end
      next_r.fault = (next_r.stk_run == 16'(dur + 16'h0001)) ||
                     (next_r.mag_run == 16'(dur + 16'h0001));
    end
  end

  function automatic logic [15:0] DUR_BASE_SHIFT(input logic [2:0] code);
    DUR_BASE_SHIFT = acm_pkg::DUR_BASE << code;
  endfunction : DUR_BASE_SHIFT

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fault = r.fault;
endmodule : acm_data_mon

/* acm_fault_monitor_props.sv */
// Concurrent checks on the interrupt and shutdown outputs of the fault monitor.
`timescale 1ns/1ps
module acm_fault_monitor_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_valid,
  input wire logic amp_active,
  input wire logic data_fault_interrupt,
  input wire logic clock_error_interrupt,
  input wire logic clock_recover_interrupt
);
  logic pend;
  // Remembers a clock error that has not yet been answered by a recovery.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pend <= 1'b0;
    else if (clock_error_interrupt) pend <= 1'b1;
    else if (clock_recover_interrupt) pend <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_recover_after_err: assert property (clock_recover_interrupt |-> pend)
    else $error("recovery without error");
  a_err_rec_apart: assert property (!(clock_error_interrupt && clock_recover_interrupt))
    else $error("error and recovery together");
  a_clk_err_off: assert property (clock_error_interrupt |-> ##[0:2] !amp_active)
    else $error("no shutdown on clock error");
  a_data_err_off: assert property (data_fault_interrupt |-> ##[0:2] !amp_active)
    else $error("no shutdown on data fault");
  a_data_from_sample: assert property (data_fault_interrupt |-> $past(sample_valid, 2))
    else $error("data fault not tied to sample");
  a_data_pulse_one: assert property (data_fault_interrupt |=> !data_fault_interrupt)
    else $error("data fault pulse too long");
  a_err_pulse_one: assert property (clock_error_interrupt |=> !clock_error_interrupt)
    else $error("clock error pulse too long");
  a_rec_pulse_one: assert property (clock_recover_interrupt |=> !clock_recover_interrupt)
    else $error("recovery pulse too long");
endmodule : acm_fault_monitor_props
bind acm_fault_monitor acm_fault_monitor_props u_props (.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
  .amp_active(amp_active), .data_fault_interrupt(data_fault_interrupt),
  .clock_error_interrupt(clock_error_interrupt), .clock_recover_interrupt(clock_recover_interrupt));

/* acm_host_model.sv */
// Host audio source model that makes the bit and frame clocks.
`timescale 1ns/1ps
module acm_host_model (
  input  wire logic run,
  output logic      bclk,
  output logic      lrclk
);
  // Half bit period for 64 bit clocks in one 192 kHz frame.
  parameter real HALF = 40.664;
  initial begin
    bclk = 1'b0;
    lrclk = 1'b0;
    forever begin
      if (run) begin
        for (int i = 0; i < 128; i++) begin
          #HALF bclk = ~bclk;
          if (i == 63) lrclk = 1'b0;
          if (i == 127) lrclk = 1'b1;
        end
      end else #HALF;
    end
  end
endmodule : acm_host_model

/* tb_top.sv */
// Self-checking bench for the audio clock and data fault monitor.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, run = 1'b1, sv = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] sd = 24'h0, v;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, bclk, lrclk, amp, dfi, cei, cri;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          n_fail = 0, total_checks = 0, cyc = 0, n_de = 0, n_ce = 0, n_cr = 0, seed = 32'h070C5E06;
  always #2.5 clk = ~clk;
  acm_host_model host (.run(run), .bclk(bclk), .lrclk(lrclk));
  acm_fault_monitor uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bclk(bclk), .lrclk(lrclk), .sample_data(sd),
    .sample_valid(sv), .amp_active(amp), .data_fault_interrupt(dfi), .clock_error_interrupt(cei),
    .clock_recover_interrupt(cri));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bq.push_back(2'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
  endtask : rd
  task automatic send(input logic [23:0] x, input int n);
    repeat (n) begin
      @(posedge clk);
      sd <= x;
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask : send
  task automatic wt(ref int c, input int t);
    for (int k = 0; k < 9000 && c < t; k++) @(posedge clk);
  endtask : wt
  // Scoreboard: pops the oldest note for each bus answer and counts interrupt pulses.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_de <= n_de + int'(dfi);
    n_ce <= n_ce + int'(cei);
    n_cr <= n_cr + int'(cri);
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (cyc == 80000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(acm_pkg::ADDR_CTRL, 32'h20, acm_pkg::RESP_OKAY);
    rd(acm_pkg::ADDR_CFG, 32'h011104, acm_pkg::RESP_OKAY);
    rd(8'h14, 32'h0, acm_pkg::RESP_SLVERR);
    wr(acm_pkg::ADDR_CFG, 32'h47);
    wr(acm_pkg::ADDR_STUCK, 32'h100);
    wr(acm_pkg::ADDR_CTRL, 32'h3B);
    repeat (4000) @(posedge clk);
    chk(34'(n_ce), 34'h0);
    send(24'($random(seed)) & 24'hFF, 100);
    chk(34'(n_de), 34'h0);
    v = 24'h200 | (24'($random(seed)) & 24'hFFF);
    send(v, 70);
    wt(n_de, 1);
    chk(34'(n_de), 34'h1);
    rd(acm_pkg::ADDR_CTRL, 32'h3A, acm_pkg::RESP_OKAY);
    wr(acm_pkg::ADDR_CTRL, 32'h3F);
    send(v, 70);
    chk(34'(n_de), 34'h1);
    wr(acm_pkg::ADDR_MAG, 32'h400);
    wr(acm_pkg::ADDR_CTRL, 32'h2B);
    send(24'h000400, 70);
    chk(34'(n_de), 34'h1);
    v = 24'h0 - (24'h800 | (24'($random(seed)) & 24'hFF));
    send(v, 70);
    wt(n_de, 2);
    chk(34'(n_de), 34'h2);
    rd(acm_pkg::ADDR_CTRL, 32'h2A, acm_pkg::RESP_OKAY);
    wr(acm_pkg::ADDR_CTRL, 32'h63);
    run <= 1'b0;
    wt(n_ce, 1);
    chk(34'(n_ce), 34'h1);
    rd(acm_pkg::ADDR_CTRL, 32'h63, acm_pkg::RESP_OKAY);
    rd(acm_pkg::ADDR_STATUS, 32'h43, acm_pkg::RESP_OKAY);
    chk(34'(amp), 34'h0);
    run <= 1'b1;
    wt(n_cr, 1);
    chk(34'(n_cr), 34'h1);
    wr(acm_pkg::ADDR_CTRL, 32'h23);
    run <= 1'b0;
    wt(n_ce, 2);
    chk(34'(n_ce), 34'h2);
    rd(acm_pkg::ADDR_CTRL, 32'h22, acm_pkg::RESP_OKAY);
    rd(acm_pkg::ADDR_STATUS, 32'h07, acm_pkg::RESP_OKAY);
    run <= 1'b1;
    repeat (6000) @(posedge clk);
    chk(34'(n_cr), 34'h1);
    wr(acm_pkg::ADDR_CTRL, 32'h23);
    run <= 1'b0;
    wt(n_ce, 3);
    chk(34'(n_ce), 34'h3);
    tally_and_finish();
  end
endmodule : tb_top
